// [smbl_assertions.sv]
// Port-level checker for the static memory controller top.
// Assumes it is bound to every instance of the top and sees its ports only.
`timescale 1ns/1ps
module smbl_assertions
(
	input wire        clk,
	input wire        reset_n,
	input wire        clk_en,
	input wire        cfg_wr_en,
	input wire [1:0]  cfg_cs,
	input wire        cfg_lane_access_type,
	input wire        req_valid,
	input wire        req_ready,
	input wire        resp_valid_q,
	input wire        boot_cfg_error,
	input wire [3:0]  chip_select_n_q,
	input wire        read_strobe_n_q,
	input wire        data_oe_q,
	input wire        external_wait_n
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);
	sequence s_take;
		req_valid && req_ready && clk_en;
	endsequence
	sequence s_done;
		##[3:300] resp_valid_q;
	endsequence
	chk_take_busy: assert property (s_take |=> !req_ready)
		else $error("ready stayed high after a request was taken");
	chk_take_done: assert property (s_take |-> s_done)
		else $error("access never completed");
	chk_cs_single: assert property ($countones(~chip_select_n_q) <= 1)
		else $error("more than one chip select low");
	chk_rd_nodrive: assert property (!read_strobe_n_q |-> !data_oe_q)
		else $error("data bus driven during a read strobe");
	chk_idle_quiet: assert property (req_ready |-> chip_select_n_q == 4'hf && read_strobe_n_q)
		else $error("strobes active while idle");
	chk_wait_hold: assert property (!read_strobe_n_q && !external_wait_n |=> !read_strobe_n_q)
		else $error("read strobe ended while wait was low");
	chk_resp_single: assert property (resp_valid_q |=> !resp_valid_q [*2])
		else $error("response pulse too long");
	chk_boot_flag: assert property (clk_en && cfg_wr_en && cfg_cs == 2'h0 |=> boot_cfg_error == $past(cfg_lane_access_type))
		else $error("boot flag wrong after boot select config");
endmodule // smbl_assertions
bind smbl_static_memory_ctrl smbl_assertions u_chk (.*);

// [smbl_cfg_mem.v]
// Per chip-select timing and mode storage, four entries, registered read.
// Assumes a synchronous configuration writer and one read index per cycle.
`timescale 1ns/1ps
`include "smbl_map.vh"
module smbl_cfg_mem
(
	input  wire        clk,
	input  wire        rst_n,
	input  wire        ce,
	input  wire        wr_en,
	input  wire [1:0]  wr_idx,
	input  wire [63:0] wr_data,
	input  wire [1:0]  rd_idx,
	output reg  [63:0] rd_data_q
);
	reg [63:0] mem_q [0:`SMBL_NUM_CS-1];
	integer i;
	always @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			for (i = 0; i < `SMBL_NUM_CS; i = i + 1)
				mem_q[i] <= 64'h0;
			rd_data_q <= 64'h0;
		end
		else if (ce)
		begin
			if (wr_en)
				mem_q[wr_idx] <= wr_data;
			rd_data_q <= mem_q[rd_idx];
		end
	end
endmodule // smbl_cfg_mem

// [smbl_lane_mux.v]
// Maps lane strobes, byte selects and low address bits onto shared pins.
// Purely combinational; inputs come from the access engine's registers.
`timescale 1ns/1ps
`include "smbl_map.vh"
module smbl_lane_mux
(
	input  wire [1:0] width,
	input  wire       lane_access_type,
	input  wire [1:0] addr_lo,
	input  wire [3:0] lanes,
	input  wire       rd_act,
	input  wire       wr_act,
	input  wire       addr_act,
	output reg        pin_lane0_addr0,
	output reg        pin_wr0,
	output reg        pin_lane1,
	output reg        pin_lane2_addr1,
	output reg        pin_lane3
);
	wire [3:0] bs_n = addr_act ? ~lanes : 4'hf;
	wire [3:0] wr_n = wr_act ? ~lanes : 4'hf;
	always @*
	begin
		pin_lane0_addr0 = 1'b1;
		pin_wr0         = ~wr_act;
		pin_lane1       = 1'b1;
		pin_lane2_addr1 = 1'b1;
		pin_lane3       = 1'b1;
		case (width)
			`SMBL_DBW_8:
			begin
				pin_lane0_addr0 = addr_lo[0];
				pin_lane2_addr1 = addr_lo[1];
			end
			`SMBL_DBW_16:
			begin
				pin_lane2_addr1 = addr_lo[1];
				if (lane_access_type == `SMBL_BAT_WRITE)
				begin
					pin_wr0   = wr_n[0];
					pin_lane1 = wr_n[1];
				end
				else
				begin
					pin_lane0_addr0 = bs_n[0];
					pin_lane1       = bs_n[1];
				end
			end
			`SMBL_DBW_32:
			begin
				if (lane_access_type == `SMBL_BAT_WRITE)
				begin
					pin_wr0         = wr_n[0];
					pin_lane1       = wr_n[1];
					pin_lane2_addr1 = wr_n[2];
					pin_lane3       = wr_n[3];
				end
				else
				begin
					pin_lane0_addr0 = bs_n[0];
					pin_lane1       = bs_n[1];
					pin_lane2_addr1 = bs_n[2];
					pin_lane3       = bs_n[3];
				end
			end
			default:
			begin
				pin_wr0 = 1'b1;
			end
		endcase
	end
endmodule // smbl_lane_mux

// [smbl_map.vh]
// Constants for the static memory bus lane multiplexer.
// Included by every design file of the block; holds definitions only.
`ifndef SMBL_MAP_VH
`define SMBL_MAP_VH
`define SMBL_NUM_CS      4
`define SMBL_ADDR_W      26
`define SMBL_DATA_W      32
`define SMBL_LANES       4
`define SMBL_CNT_W       6
`define SMBL_DBW_8       2'h0
`define SMBL_DBW_16      2'h1
`define SMBL_DBW_32      2'h2
`define SMBL_BAT_SELECT  1'h0
`define SMBL_BAT_WRITE   1'h1
`define SMBL_SLOW_SETUP  6'h01
`define SMBL_SLOW_PULSE  6'h01
`define SMBL_SLOW_CYCLE  6'h03
`define SMBL_BOOT_CS     2'h0
`define SMBL_CNT_ONE     6'h01
`define SMBL_CNT_ZERO    6'h00
`endif

// [smbl_mem_model.sv]
// Behavioural external memory: sixteen words and a wait generator.
// Assumes synchronous controller pins; mode_wr names the lane scheme wired.
`timescale 1ns/1ps
module smbl_mem_model
(
	input  wire         clk,
	input  wire         mode_wr,
	input  wire [7:0]   wait_len,
	input  wire [3:0]   cs_n,
	input  wire         rd_n,
	input  wire         we_n,
	input  wire         l0_n,
	input  wire         l1_n,
	input  wire         l2_n,
	input  wire         l3_n,
	input  wire [23:0]  addr,
	input  wire [31:0]  dout,
	input  wire         doe,
	output logic [31:0] din,
	output wire         wait_n
);
	logic [31:0] mem [0:15];
	logic [7:0]  cnt_q;
	logic        rd_q;
	wire  [3:0]  we;
	integer      i;
	// Write strobe parts take one strobe per lane; byte select parts gate lanes by one enable.
	assign we = mode_wr ? ~{l3_n, l2_n, l1_n, we_n} : (we_n ? 4'h0 : ~{l3_n, l2_n, l1_n, l0_n});
	assign wait_n = (cnt_q == 8'h00);
	initial
	begin
		for (i = 0; i < 16; i = i + 1)
			mem[i] = 32'h0;
		cnt_q = 8'h00;
		rd_q = 1'b1;
		din = 32'h0;
	end
	always @(posedge clk)
	begin
		rd_q <= rd_n;
		if (rd_q && !rd_n)
			cnt_q <= wait_len;
		else if (cnt_q != 8'h00)
			cnt_q <= cnt_q - 8'h01;
		for (i = 0; i < 4; i = i + 1)
			if (cs_n != 4'hf && doe && we[i])
				mem[addr[3:0]][8*i +: 8] <= dout[8*i +: 8];
		// A released bus shows the inverse of its last value, never a held copy.
		din <= (!rd_n && cs_n != 4'hf) ? mem[addr[3:0]] : ~din;
	end
endmodule // smbl_mem_model

// [smbl_static_memory_ctrl.v]
// Static memory controller front end: access engine and pin drivers.
// Assumes requests held stable until done, and synchronous external pins.
`timescale 1ns/1ps
`include "smbl_map.vh"
// Overview of operation
// - Four chip selects and 26 address bits, 64 Mbytes each.
// - Bus width 8, 16 or 32 bits chosen per chip select.
// - Significant address bits depend on the chip select's bus width.
// - Wide buses use write strobes or byte selects per access type.
// - Sixteen-bit write strobe mode: strobes 0 and 1, one read strobe.
// - Thirty-two-bit write strobe mode: strobes 0 to 3, one read strobe.
// - Boot chip select may not use the write strobe access type.
// - Byte select mode: one select per lane, common read and write.
// - Byte selects 0,1 on 16-bit; 0 to 3 on 32-bit buses.
// - Low address bits unused on wide buses share strobe pins.
// - Unused strobe kind for the chosen access type stays idle.
// - Shared pin 2 is byte select, write strobe or address bit 1.
// - Strobes and selects active low; data bus bidirectional.
// - Low wait input stretches the access in progress.
// - Per chip select read and write setup, pulse and cycle.
// - Programmable data float time per chip select.
// - Slow clock mode replaces waveforms with fixed slow ones.
// - Page mode burst reads with page size 4 to 32 bytes.
// - Byte selects active in setup, pulse and hold only; address held from load onward.
module smbl_static_memory_ctrl
(
	input  wire        clk,
	input  wire        reset_n,
	input  wire        clk_en,
	input  wire        cfg_wr_en,
	input  wire [1:0]  cfg_cs,
	input  wire [1:0]  cfg_bus_width_sel,
	input  wire        cfg_lane_access_type,
	input  wire [5:0]  cfg_rd_setup,
	input  wire [5:0]  cfg_rd_pulse,
	input  wire [5:0]  cfg_rd_cycle,
	input  wire [5:0]  cfg_wr_setup,
	input  wire [5:0]  cfg_wr_pulse,
	input  wire [5:0]  cfg_wr_cycle,
	input  wire [3:0]  cfg_float,
	input  wire [2:0]  cfg_page_size,
	input  wire        slow_clock_mode,
	input  wire        req_valid,
	input  wire        req_write,
	input  wire [1:0]  req_cs,
	input  wire [25:0] req_addr,
	input  wire [3:0]  req_lanes,
	input  wire [31:0] req_wdata,
	output wire        req_ready,
	output reg         resp_valid_q,
	output reg  [31:0] resp_rdata_q,
	output wire        boot_cfg_error,
	output reg  [3:0]  chip_select_n_q,
	output reg         read_strobe_n_q,
	output wire        write_enable_strobe_n,
	output wire        lane1_write_strobe_n,
	output wire        shared_lane0_addr0_pin,
	output wire        shared_lane2_addr1_pin,
	output wire        lane3_write_strobe_n,
	output reg  [23:0] addr_hi_q,
	input  wire [31:0] data_in,
	output reg  [31:0] data_out_q,
	output reg         data_oe_q,
	input  wire        external_wait_n
);
	localparam ST_IDLE  = 3'h0;
	localparam ST_LOAD  = 3'h1;
	localparam ST_SETUP = 3'h2;
	localparam ST_PULSE = 3'h3;
	localparam ST_HOLD  = 3'h4;
	localparam ST_FLOAT = 3'h5;

	reg         rst_s1_q;
	reg         rst_n_q;
	reg  [2:0]  state_q;
	reg  [5:0]  cnt_q;
	reg  [3:0]  float_q;
	reg         wr_q;
	reg  [1:0]  cs_q;
	reg  [1:0]  addr_lo_q;
	reg  [3:0]  lanes_q;
	reg         page_open_q;
	reg  [1:0]  page_cs_q;
	reg  [25:0] page_base_q;
	wire [63:0] cfg_rd;
	wire [63:0] cfg_wd;
	wire [1:0]  width    = cfg_rd[1:0];
	wire        lane_access_type      = cfg_rd[2];
	wire [5:0]  t_setup  = slow_clock_mode ? `SMBL_SLOW_SETUP
	                     : (wr_q ? cfg_rd[26:21] : cfg_rd[8:3]);
	wire [5:0]  t_pulse  = slow_clock_mode ? `SMBL_SLOW_PULSE
	                     : (wr_q ? cfg_rd[32:27] : cfg_rd[14:9]);
	wire [5:0]  t_cycle  = slow_clock_mode ? `SMBL_SLOW_CYCLE
	                     : (wr_q ? cfg_rd[38:33] : cfg_rd[20:15]);
	wire [3:0]  t_float  = cfg_rd[42:39];
	wire [2:0]  page_sz  = cfg_rd[45:43];

	// Reset release is synchronised; only the second flop is used.
	always @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			rst_s1_q <= 1'b0;
			rst_n_q  <= 1'b0;
		end
		else
		begin
			rst_s1_q <= 1'b1;
			rst_n_q  <= rst_s1_q;
		end
	end

	// Page size code n gives 4 << n bytes, so 0..3 cover 4 to 32 bytes.
	function [25:0] page_mask;
		input [2:0] code;
		begin
			case (code)
				3'h0:    page_mask = 26'h3fffffc;
				3'h1:    page_mask = 26'h3fffff8;
				3'h2:    page_mask = 26'h3fffff0;
				3'h3:    page_mask = 26'h3ffffe0;
				default: page_mask = 26'h3ffffff;
			endcase
		end
	endfunction

	assign cfg_wd = {18'h0, cfg_page_size, cfg_float, cfg_wr_cycle, cfg_wr_pulse,
	                 cfg_wr_setup, cfg_rd_cycle, cfg_rd_pulse, cfg_rd_setup,
	                 cfg_lane_access_type, cfg_bus_width_sel};

	smbl_cfg_mem u_cfg
	(
		.clk       (clk),
		.rst_n     (rst_n_q),
		.ce        (clk_en),
		.wr_en     (cfg_wr_en),
		.wr_idx    (cfg_cs),
		.wr_data   (cfg_wd),
		.rd_idx    (state_q == ST_IDLE ? req_cs : cs_q),
		.rd_data_q (cfg_rd)
	);

	// The boot chip select must not be set for write strobe lanes.
	reg boot_err_q;
	always @(posedge clk or negedge rst_n_q)
	begin
		if (!rst_n_q)
			boot_err_q <= 1'b0;
		else if (clk_en && cfg_wr_en && cfg_cs == `SMBL_BOOT_CS)
			boot_err_q <= (cfg_lane_access_type == `SMBL_BAT_WRITE);
	end
	assign boot_cfg_error = boot_err_q;

	assign req_ready = (state_q == ST_IDLE);

	wire in_setup = (state_q == ST_SETUP);
	wire in_pulse = (state_q == ST_PULSE);
	wire in_hold  = (state_q == ST_HOLD);
	wire wait_hit = in_pulse && !external_wait_n;
	wire pulse_end = in_pulse && external_wait_n && cnt_q == t_pulse;
	wire cyc_end  = (in_hold || pulse_end) && (cnt_q + t_setup >= t_cycle);
	wire page_hit = page_open_q && page_cs_q == req_cs && !req_write
	              && ((req_addr & page_mask(page_sz)) == page_base_q);

	always @(posedge clk or negedge rst_n_q)
	begin
		if (!rst_n_q)
		begin
			state_q         <= ST_IDLE;
			cnt_q           <= `SMBL_CNT_ZERO;
			float_q         <= 4'h0;
			wr_q            <= 1'b0;
			cs_q            <= 2'h0;
			addr_lo_q       <= 2'h0;
			lanes_q         <= 4'h0;
			addr_hi_q       <= 24'h0;
			chip_select_n_q <= 4'hf;
			read_strobe_n_q <= 1'b1;
			data_out_q      <= 32'h0;
			data_oe_q       <= 1'b0;
			resp_valid_q    <= 1'b0;
			resp_rdata_q    <= 32'h0;
			page_open_q     <= 1'b0;
			page_cs_q       <= 2'h0;
			page_base_q     <= 26'h0;
		end
		else if (clk_en)
		begin
			resp_valid_q <= 1'b0;
			case (state_q)
				ST_IDLE:
				begin
					if (req_valid)
					begin
						wr_q       <= req_write;
						cs_q       <= req_cs;
						addr_hi_q  <= req_addr[25:2];
						addr_lo_q  <= req_addr[1:0];
						lanes_q    <= req_lanes;
						data_out_q <= req_wdata;
						state_q    <= ST_LOAD;
					end
				end
				ST_LOAD:
				begin
					cnt_q   <= `SMBL_CNT_ONE;
					chip_select_n_q <= ~(4'h1 << cs_q);
					// A page hit skips setup, so its read strobe must fall here as well.
					if ((page_hit && !wr_q && slow_clock_mode == 1'b0)
					    || t_setup == `SMBL_CNT_ZERO)
					begin
						state_q         <= ST_PULSE;
						read_strobe_n_q <= wr_q;
					end
					else
						state_q <= ST_SETUP;
					page_open_q <= 1'b0;
				end
				ST_SETUP:
				begin
					if (cnt_q >= t_setup)
					begin
						cnt_q           <= `SMBL_CNT_ONE;
						state_q         <= ST_PULSE;
						read_strobe_n_q <= wr_q;
						data_oe_q       <= wr_q;
					end
					else
						cnt_q <= cnt_q + `SMBL_CNT_ONE;
				end
				ST_PULSE:
				begin
					data_oe_q <= wr_q;
					if (wait_hit)
						cnt_q <= cnt_q;
					else if (pulse_end)
					begin
						read_strobe_n_q <= 1'b1;
						if (!wr_q)
							resp_rdata_q <= data_in;
						cnt_q   <= cnt_q + t_setup + `SMBL_CNT_ONE;
						state_q <= cyc_end ? ST_FLOAT : ST_HOLD;
					end
					else
						cnt_q <= cnt_q + `SMBL_CNT_ONE;
				end
				ST_HOLD:
				begin
					if (cnt_q >= t_cycle)
						state_q <= ST_FLOAT;
					else
						cnt_q <= cnt_q + `SMBL_CNT_ONE;
				end
				ST_FLOAT:
				begin
					chip_select_n_q <= 4'hf;
					data_oe_q       <= 1'b0;
					if (float_q >= t_float)
					begin
						float_q      <= 4'h0;
						resp_valid_q <= 1'b1;
						page_open_q  <= !wr_q;
						page_cs_q    <= cs_q;
						page_base_q  <= {addr_hi_q, addr_lo_q} & page_mask(page_sz);
						state_q      <= ST_IDLE;
					end
					else
						float_q <= float_q + 4'h1;
				end
				default:
				begin
					state_q <= ST_IDLE;
				end
			endcase
		end
	end

	wire addr_act = (state_q != ST_IDLE);
	wire wr_act   = in_pulse && wr_q;

	smbl_lane_mux u_mux
	(
		.width           (width),
		.lane_access_type             (lane_access_type),
		.addr_lo         (addr_lo_q),
		.lanes           (lanes_q),
		.rd_act          (in_pulse && !wr_q),
		.wr_act          (wr_act),
		.addr_act        (addr_act && (in_setup || in_pulse || in_hold)),
		.pin_lane0_addr0 (shared_lane0_addr0_pin),
		.pin_wr0         (write_enable_strobe_n),
		.pin_lane1       (lane1_write_strobe_n),
		.pin_lane2_addr1 (shared_lane2_addr1_pin),
		.pin_lane3       (lane3_write_strobe_n)
	);
endmodule // smbl_static_memory_ctrl

// [tb_static_memory_bus_lane_mux.sv]
// Self-checking bench for the static memory controller top.
// Assumes the memory model answers on the far side of the pins.
`timescale 1ns/1ps
`include "smbl_map.vh"
module tb_static_memory_bus_lane_mux;
	logic        clk, reset_n, cfg_wr_en, cfg_bat, req_valid, req_write, mode_wr;
	logic        clk_en, slow;
	logic [2:0]  psz;
	logic [1:0]  cfg_cs, cfg_w, req_cs;
	logic [5:0]  tcy;
	logic [25:0] req_addr, k;
	logic [3:0]  req_lanes;
	logic [31:0] req_wdata;
	logic [7:0]  wait_len, p;
	wire         req_ready, resp_valid_q, boot_err, rd_n, we_n, l1_n, a0_n, a1_n, l3_n, doe, wait_n;
	wire  [31:0] rdata, dout, din;
	wire  [3:0]  cs_n;
	wire  [23:0] addr_hi;
	int          error_cnt, total_checks, n;
	smbl_static_memory_ctrl uut (.clk(clk), .reset_n(reset_n), .clk_en(clk_en),
		.cfg_wr_en(cfg_wr_en), .cfg_cs(cfg_cs), .cfg_bus_width_sel(cfg_w),
		.cfg_lane_access_type(cfg_bat), .cfg_rd_setup(6'h02), .cfg_rd_pulse(6'h03),
		.cfg_rd_cycle(tcy), .cfg_wr_setup(6'h02), .cfg_wr_pulse(6'h03), .cfg_wr_cycle(tcy),
		.cfg_float(4'h1), .cfg_page_size(psz), .slow_clock_mode(slow), .req_valid(req_valid),
		.req_write(req_write), .req_cs(req_cs), .req_addr(req_addr), .req_lanes(req_lanes),
		.req_wdata(req_wdata), .req_ready(req_ready), .resp_valid_q(resp_valid_q),
		.resp_rdata_q(rdata), .boot_cfg_error(boot_err), .chip_select_n_q(cs_n),
		.read_strobe_n_q(rd_n), .write_enable_strobe_n(we_n), .lane1_write_strobe_n(l1_n),
		.shared_lane0_addr0_pin(a0_n), .shared_lane2_addr1_pin(a1_n),
		.lane3_write_strobe_n(l3_n), .addr_hi_q(addr_hi), .data_in(din), .data_out_q(dout),
		.data_oe_q(doe), .external_wait_n(wait_n));
	smbl_mem_model u_mem (.clk(clk), .mode_wr(mode_wr), .wait_len(wait_len), .cs_n(cs_n),
		.rd_n(rd_n), .we_n(we_n), .l0_n(a0_n), .l1_n(l1_n), .l2_n(a1_n), .l3_n(l3_n),
		.addr(addr_hi), .dout(dout), .doe(doe), .din(din), .wait_n(wait_n));
	task automatic results;
	begin
		if (error_cnt == 0 && total_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	end
	endtask
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
	begin
		total_checks++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	end
	endtask
	task automatic cfg(input logic [1:0] c, input logic [1:0] w, input logic b, input logic [5:0] cy);
	begin
		@(posedge clk);
		#1;
		cfg_cs = c;
		cfg_w = w;
		cfg_bat = b;
		tcy = cy;
		cfg_wr_en = 1'b1;
		@(posedge clk);
		#1;
		cfg_wr_en = 1'b0;
	end
	endtask
	// Holds the request until the response pulse; pins are sampled in the read pulse.
	task automatic acc(input logic w, input logic [1:0] c, input logic [25:0] a,
		input logic [3:0] ln, input logic [31:0] d);
		logic rdy;
		logic tk;
		int   i;
	begin
		@(posedge clk);
		#1;
		req_write = w;
		req_cs = c;
		req_addr = a;
		req_lanes = ln;
		req_wdata = d;
		req_valid = 1'b1;
		tk = 1'b0;
		n = 0;
		for (i = 0; i < 400; i++)
		begin
			rdy = req_ready;
			@(posedge clk);
			#1;
			if (tk)
				n++;
			else if (rdy === 1'b1)
				tk = 1'b1;
			if (cs_n !== 4'hf && rd_n === 1'b0)
				p = {l3_n, a1_n, l1_n, a0_n, cs_n};
			if (tk && resp_valid_q === 1'b1)
				break;
		end
		req_valid = 1'b0;
		if (i == 400)
		begin
			check(1'b0, 1'b1);
			results();
		end
	end
	endtask
	task automatic t_bs32;
	begin
		cfg(2'h1, `SMBL_DBW_32, `SMBL_BAT_SELECT, 6'h07);
		acc(1'b1, 2'h1, 26'h10, 4'hf, 32'h1234abcd);
		check(n, 10);
		acc(1'b0, 2'h1, 26'h10, 4'h5, 32'h0);
		check(rdata, 32'h1234abcd);
		check(p, 8'had);
		acc(1'b1, 2'h1, 26'h10, 4'h6, 32'hffffffff);
		acc(1'b0, 2'h1, 26'h10, 4'hf, 32'h0);
		check(rdata, 32'h12ffffcd);
	end
	endtask
	task automatic t_wr32;
	begin
		mode_wr = 1'b1;
		cfg(2'h2, `SMBL_DBW_32, `SMBL_BAT_WRITE, 6'h09);
		acc(1'b1, 2'h2, 26'h20, 4'hf, 32'h0);
		check(n, 12);
		acc(1'b1, 2'h2, 26'h20, 4'h9, 32'haabbccdd);
		acc(1'b0, 2'h2, 26'h20, 4'hf, 32'h0);
		check(rdata, 32'haa0000dd);
		check(p[7:4], 4'hf);
		cfg(2'h2, `SMBL_DBW_16, `SMBL_BAT_WRITE, 6'h09);
		acc(1'b1, 2'h2, 26'h22, 4'h2, 32'h0000ee00);
		acc(1'b0, 2'h2, 26'h22, 4'h3, 32'h0);
		check(rdata, 32'haa00eedd);
		check(p[7:4], 4'hf);
		mode_wr = 1'b0;
	end
	endtask
	task automatic t_16;
	begin
		cfg(2'h3, `SMBL_DBW_16, `SMBL_BAT_SELECT, 6'h07);
		acc(1'b0, 2'h3, 26'h2, 4'h3, 32'h0);
		check(p, 8'hc7);
		acc(1'b0, 2'h3, 26'h1, 4'h1, 32'h0);
		check(p, 8'ha7);
	end
	endtask
	task automatic t_8;
	begin
		cfg(2'h0, `SMBL_DBW_8, `SMBL_BAT_SELECT, 6'h07);
		check(boot_err, 1'b0);
		for (k = 26'h0; k < 26'h4; k++)
		begin
			acc(1'b0, 2'h0, k, 4'h1, 32'h0);
			check({p[6], p[4]}, k[1:0]);
		end
		cfg(2'h0, `SMBL_DBW_32, `SMBL_BAT_WRITE, 6'h07);
		check(boot_err, 1'b1);
	end
	endtask
	task automatic t_wait;
	begin
		acc(1'b0, 2'h1, 26'h10, 4'hf, 32'h0);
		check(n, 10);
		wait_len = 8'h06;
		acc(1'b0, 2'h1, 26'h14, 4'hf, 32'h0);
		check(n, 16);
		wait_len = 8'h00;
	end
	endtask
	// Slow waveforms, a page hit that skips setup, and a clock-enable freeze mid-access.
	task automatic t_more;
	begin
		slow = 1'b1;
		acc(1'b0, 2'h1, 26'h14, 4'hf, 32'h0);
		check(n, 6);
		slow = 1'b0;
		psz = 3'h0;
		cfg(2'h1, `SMBL_DBW_32, `SMBL_BAT_SELECT, 6'h07);
		acc(1'b0, 2'h1, 26'h10, 4'hf, 32'h0);
		check(n, 10);
		p = 8'h00;
		acc(1'b0, 2'h1, 26'h12, 4'hf, 32'h0);
		check(n, 8);
		check(p, 8'h0d);
		check(rdata, 32'h12ffffcd);
		psz = 3'h7;
		fork
			acc(1'b1, 2'h1, 26'h10, 4'hf, 32'h12ffffcd);
			begin
				repeat (4) @(posedge clk);
				#1;
				clk_en = 1'b0;
				repeat (5) @(posedge clk);
				#1;
				clk_en = 1'b1;
			end
		join
		check(n, 15);
	end
	endtask
	initial
	begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	initial
	begin
		error_cnt = 0;
		total_checks = 0;
		reset_n = 1'b0;
		{cfg_wr_en, cfg_bat, req_valid, req_write, mode_wr, cfg_cs, cfg_w, req_cs} = 11'h0;
		{req_addr, req_lanes, req_wdata, wait_len, p} = 78'h0;
		tcy = 6'h07;
		clk_en = 1'b1;
		slow = 1'b0;
		psz = 3'h7;
		repeat (3) @(posedge clk);
		#1;
		reset_n = 1'b1;
		repeat (3) @(posedge clk);
		t_bs32();
		t_wr32();
		t_16();
		t_8();
		t_wait();
		t_more();
		results();
	end
endmodule // tb_static_memory_bus_lane_mux
